// *** vac_pkg.sv ***
`default_nettype none
package vac_pkg;
  localparam logic [15:0] IO_INDEX = 16'h03c0;
  localparam logic [15:0] IO_DATA_RD = 16'h03c1;
  localparam logic [15:0] IO_STAT_MONO = 16'h03ba;
  localparam logic [15:0] IO_STAT_COLR = 16'h03da;
  localparam logic [4:0] IDX_PAL_LAST = 5'h0f;
  localparam logic [4:0] IDX_MODE = 5'h10;
  localparam logic [4:0] IDX_BORDER = 5'h11;
  localparam logic [4:0] IDX_PLANE = 5'h12;
  localparam logic [4:0] IDX_PAN = 5'h13;
  localparam logic [4:0] IDX_PAD = 5'h14;
  localparam int IX_PDE = 5;
  localparam int MD_GFX = 0;
  localparam int MD_MONO = 1;
  localparam int MD_LGC = 2;
  localparam int MD_BLINK = 3;
  localparam int MD_SPLIT = 5;
  localparam int MD_256 = 6;
  localparam int MD_V54 = 7;
  localparam logic [7:0] MASK_INDEX = 8'h3f;
  localparam logic [7:0] MASK_PAL = 8'h3f;
  localparam logic [7:0] MASK_MODE = 8'hef;
  localparam logic [7:0] MASK_PLANE = 8'h3f;
  localparam logic [7:0] MASK_PAN = 8'h0f;
  localparam logic [7:0] MASK_PAD = 8'h0f;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] LGC_FIRST = 8'hc0;
  localparam logic [7:0] LGC_LAST = 8'hdf;
  localparam int CHAR_BLINK_HALF = 16;
  localparam int CURSOR_BLINK_HALF = 8;
  localparam logic [3:0] PAN_NINE_ZERO = 4'h8;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } vac_io_t;
  typedef struct packed {
    logic active;
    logic glyph_dot;
    logic ninth_dot;
    logic cursor;
    logic [7:0] char_code;
    logic [7:0] attr;
    logic [3:0] plane;
  } vac_dot_t;
endpackage : vac_pkg
`default_nettype wire

// *** vac_blink.sv ***
`timescale 1ns/1ps
`default_nettype none
module vac_blink #(
  parameter int CHAR_HALF = vac_pkg::CHAR_BLINK_HALF,
  parameter int CURSOR_HALF = vac_pkg::CURSOR_BLINK_HALF
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic retrace_pulse,
  output logic char_on,
  output logic cursor_on
);
  localparam int CW = $clog2(2 * CHAR_HALF);
  localparam int CB = $clog2(CHAR_HALF);
  localparam int UB = $clog2(CURSOR_HALF);
  logic [CW-1:0] cnt;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
    end else if (ce && retrace_pulse) begin
      cnt <= cnt + 1'b1;
    end
  end

  assign char_on = ~cnt[CB];
  assign cursor_on = ~cnt[UB];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_blink_step: assert property (ce && retrace_pulse |=> cnt == $past(cnt) + 1'b1)
    else $error("blink counter did not advance on retrace");
  a_char_phase: assert property (ce && retrace_pulse && cnt == CW'(CHAR_HALF - 1)
    |=> !char_on)
    else $error("char blink phase did not turn off after sixteen retraces");
  a_cursor_phase: assert property (ce && retrace_pulse && cnt == CW'(CURSOR_HALF - 1)
    |=> !cursor_on && char_on)
    else $error("cursor phase did not turn off after eight retraces");
  c_char_wrap: cover property (ce && retrace_pulse && cnt == '1);
endmodule : vac_blink
`default_nettype wire

// *** vac_pan.sv ***
`timescale 1ns/1ps
`default_nettype none
module vac_pan (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [3:0] pan_code,
  input wire logic nine_dot,
  input wire logic mode_256,
  input wire logic enhanced_map,
  input wire logic split_enable_a,
  input wire logic line_compare_match,
  input wire logic vsync,
  output logic [3:0] shift
);
  logic below_split;

  function automatic logic [3:0] pan_decode(input logic [3:0] code, input logic nine,
                                           input logic m256);
    logic [3:0] r;
    r = 4'h0;
    if (m256) begin
      r = {2'b00, code[2:1]};
    end else if (nine) begin
      if (code == vac_pkg::PAN_NINE_ZERO) r = 4'h0;
      else if (!code[3]) r = code + 4'h1;
    end else begin
      r = {1'b0, code[2:0]};
    end
    return r;
  endfunction : pan_decode

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      below_split <= 1'b0;
    end else if (ce) begin
      if (line_compare_match) below_split <= 1'b1;
      else if (vsync) below_split <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shift <= 4'h0;
    end else if (ce) begin
      if (enhanced_map || (split_enable_a && below_split)) shift <= 4'h0;
      else shift <= pan_decode(pan_code, nine_dot, mode_256);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_split_zero: assert property (ce && split_enable_a && below_split |=> shift == 4'h0)
    else $error("pan not forced to zero below split");
  a_nine_code8: assert property (ce && !enhanced_map && !(split_enable_a && below_split)
    && nine_dot && !mode_256 && pan_code == 4'h8 |=> shift == 4'h0)
    else $error("nine-dot code 8 did not give zero shift");
  a_half_code: assert property (ce && !enhanced_map && !(split_enable_a && below_split)
    && mode_256 && pan_code == 4'h6 |=> shift == 4'h3)
    else $error("256-colour pan is not half the code");
  c_split_pan: cover property (split_enable_a && line_compare_match ##[1:50] vsync);
endmodule : vac_pan
`default_nettype wire

// *** vac_attr_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module vac_attr_ctrl (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire vac_pkg::vac_io_t io,
  output logic [7:0] io_rdata,
  input wire vac_pkg::vac_dot_t dot,
  input wire logic vertical_retrace_pulse,
  input wire logic line_compare_match,
  input wire logic vsync,
  input wire logic nine_dot_mode,
  input wire logic pixel_path_width_bit,
  input wire logic enhanced_mapping_bit,
  output logic [7:0] video_out,
  output logic video_valid,
  output logic [3:0] pan_shift,
  output logic [1:0] status_bits,
  output logic palette_display_enable
);
  logic [5:0] attr_index;
  logic index_data_toggle;
  logic [5:0] palette_entries [16];
  logic [7:0] attr_mode_control;
  logic [7:0] border_colour;
  logic [5:0] plane_enable;
  logic [3:0] horizontal_pan;
  logic [3:0] high_bit_padding;
  logic [7:0] rd_mux;
  logic char_on;
  logic cursor_on;
  logic last_glyph;
  logic half_phase;
  logic [3:0] low_hold;
  logic [3:0] fg;
  logic [3:0] bg;
  logic pix_on;
  logic [3:0] col_raw;
  logic [3:0] col;
  logic [5:0] pal_out;
  logic [5:0] next_v;
  logic [1:0] next_status;

  wire index_wr = io.wr && io.addr == vac_pkg::IO_INDEX;
  wire data_wr = index_wr && index_data_toggle;
  wire status_rd = io.rd && (io.addr == vac_pkg::IO_STAT_MONO
                             || io.addr == vac_pkg::IO_STAT_COLR);
  // palette owned by display only in 6-bit path
  wire pde_eff = attr_index[vac_pkg::IX_PDE] || pixel_path_width_bit;
  wire host_pal_lock = attr_index[vac_pkg::IX_PDE] && !pixel_path_width_bit;
  wire gfx = attr_mode_control[vac_pkg::MD_GFX];
  wire mono = attr_mode_control[vac_pkg::MD_MONO];
  wire lgc = attr_mode_control[vac_pkg::MD_LGC];
  wire blink_enable = attr_mode_control[vac_pkg::MD_BLINK];
  wire split_enable_a = attr_mode_control[vac_pkg::MD_SPLIT];
  wire eight_bit_colour_mode = attr_mode_control[vac_pkg::MD_256];
  wire video_bits_5_4_select = attr_mode_control[vac_pkg::MD_V54];
  wire [1:0] video_test_select = plane_enable[5:4];
  wire lgc_code = dot.char_code >= vac_pkg::LGC_FIRST
                  && dot.char_code <= vac_pkg::LGC_LAST;

  vac_blink u_blink (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .retrace_pulse(vertical_retrace_pulse),
    .char_on(char_on),
    .cursor_on(cursor_on)
  );

  vac_pan u_pan (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .pan_code(horizontal_pan),
    .nine_dot(nine_dot_mode),
    .mode_256(eight_bit_colour_mode),
    .enhanced_map(enhanced_mapping_bit),
    .split_enable_a(split_enable_a),
    .line_compare_match(line_compare_match),
    .vsync(vsync),
    .shift(pan_shift)
  );

  // host access: index/data toggle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      index_data_toggle <= 1'b0;
    end else if (ce) begin
      if (status_rd) index_data_toggle <= 1'b0;
      else if (index_wr) index_data_toggle <= ~index_data_toggle;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      attr_index <= vac_pkg::RST_REG[5:0];
    end else if (ce && index_wr && !index_data_toggle) begin
      attr_index <= io.wdata[5:0] & vac_pkg::MASK_INDEX[5:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 16; i++) palette_entries[i] <= vac_pkg::RST_REG[5:0];
    end else if (ce && data_wr && attr_index[4:0] <= vac_pkg::IDX_PAL_LAST
                 && !host_pal_lock) begin
      palette_entries[attr_index[3:0]] <= io.wdata[5:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      attr_mode_control <= vac_pkg::RST_REG;
      border_colour <= vac_pkg::RST_REG;
      plane_enable <= vac_pkg::RST_REG[5:0];
      horizontal_pan <= vac_pkg::RST_REG[3:0];
      high_bit_padding <= vac_pkg::RST_REG[3:0];
    end else if (ce && data_wr) begin
      case (attr_index[4:0])
        vac_pkg::IDX_MODE: attr_mode_control <= io.wdata & vac_pkg::MASK_MODE;
        vac_pkg::IDX_BORDER: border_colour <= io.wdata;
        vac_pkg::IDX_PLANE: plane_enable <= io.wdata[5:0] & vac_pkg::MASK_PLANE[5:0];
        vac_pkg::IDX_PAN: horizontal_pan <= io.wdata[3:0] & vac_pkg::MASK_PAN[3:0];
        vac_pkg::IDX_PAD: high_bit_padding <= io.wdata[3:0] & vac_pkg::MASK_PAD[3:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    if (attr_index[4:0] <= vac_pkg::IDX_PAL_LAST) begin
      if (!host_pal_lock) rd_mux = {2'b00, palette_entries[attr_index[3:0]]};
    end else begin
      case (attr_index[4:0])
        vac_pkg::IDX_MODE: rd_mux = attr_mode_control;
        vac_pkg::IDX_BORDER: rd_mux = border_colour;
        vac_pkg::IDX_PLANE: rd_mux = {2'b00, plane_enable};
        vac_pkg::IDX_PAN: rd_mux = {4'h0, horizontal_pan};
        vac_pkg::IDX_PAD: rd_mux = {4'h0, high_bit_padding};
        default: rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      io_rdata <= 8'h00;
    end else if (ce && io.rd) begin
      if (io.addr == vac_pkg::IO_INDEX) io_rdata <= {2'b00, attr_index};
      else if (io.addr == vac_pkg::IO_DATA_RD) io_rdata <= rd_mux;
      else io_rdata <= 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      palette_display_enable <= 1'b0;
    end else if (ce) begin
      palette_display_enable <= pde_eff;
    end
  end

  // text attribute decode
  always_comb begin
    if (mono) begin
      fg = (dot.attr[2:0] == 3'b000) ? 4'h0 : {dot.attr[3], 3'b111};
      bg = (dot.attr[6:4] == 3'b111) ? {dot.attr[7] && !blink_enable, 3'b111} : 4'h0;
    end else begin
      fg = dot.attr[3:0];
      bg = blink_enable ? {1'b0, dot.attr[6:4]} : dot.attr[7:4];
    end
  end

  always_comb begin
    if (dot.ninth_dot) pix_on = lgc && lgc_code && last_glyph;
    else pix_on = dot.glyph_dot;
    if (blink_enable && dot.attr[7] && !char_on) pix_on = 1'b0;
    if (dot.cursor && cursor_on) pix_on = 1'b1;
  end

  always_comb begin
    col_raw = gfx ? dot.plane : (pix_on ? fg : bg);
    col = col_raw & plane_enable[3:0];
    if (gfx && blink_enable && !char_on) col[3] = ~col[3];
    // blocked palette drives black
    pal_out = pde_eff ? palette_entries[col] : 6'h00;
    next_v = pal_out;
    if (video_bits_5_4_select) next_v[5:4] = high_bit_padding[1:0];
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      last_glyph <= 1'b0;
    end else if (ce && dot.active && !dot.ninth_dot) begin
      last_glyph <= dot.glyph_dot;
    end
  end

  // pixel output stage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      video_out <= 8'h00;
      video_valid <= 1'b0;
      half_phase <= 1'b0;
      low_hold <= 4'h0;
    end else if (ce) begin
      if (!dot.active) begin
        video_out <= border_colour;
        video_valid <= 1'b1;
        half_phase <= 1'b0;
      end else if (eight_bit_colour_mode) begin
        half_phase <= ~half_phase;
        if (!half_phase) begin
          low_hold <= next_v[3:0];
          video_valid <= 1'b0;
        end else begin
          video_out <= {low_hold, next_v[3:0]};
          video_valid <= 1'b1;
        end
      end else begin
        video_out <= {high_bit_padding[3:2], next_v};
        video_valid <= 1'b1;
        half_phase <= 1'b0;
      end
    end
  end

  always_comb begin
    case (video_test_select)
      2'b00: next_status = {video_out[2], video_out[0]};
      2'b01: next_status = {video_out[5], video_out[4]};
      2'b10: next_status = {video_out[3], video_out[1]};
      2'b11: next_status = {video_out[7], video_out[6]};
      default: next_status = 2'b00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      status_bits <= 2'b00;
    end else if (ce) begin
      status_bits <= next_status;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_status_clears: assert property (ce && status_rd |=> !index_data_toggle)
    else $error("status read did not select the index");
  a_write_flips: assert property (ce && index_wr && !status_rd
    |=> index_data_toggle != $past(index_data_toggle))
    else $error("port write did not flip the toggle");
  a_index_load: assert property (ce && index_wr && !index_data_toggle
    |=> attr_index == ($past(io.wdata[5:0])))
    else $error("index not loaded from first write");
  a_index_read: assert property (ce && io.rd && io.addr == vac_pkg::IO_INDEX
    |=> io_rdata == {2'b00, attr_index})
    else $error("index read returned wrong value");
  a_pal_locked: assert property (ce && data_wr && host_pal_lock
    && attr_index[4:0] <= vac_pkg::IDX_PAL_LAST
    |=> $stable(palette_entries[attr_index[3:0]]))
    else $error("host wrote palette while display owns it");
  a_mode_reserved: assert property (attr_mode_control[4] == 1'b0)
    else $error("reserved mode bit is set");
  a_border_out: assert property (ce && !dot.active |=> video_out == $past(border_colour))
    else $error("border colour not shown outside screen");
  a_pad_high: assert property (ce && dot.active && !eight_bit_colour_mode
    |=> video_out[7:6] == $past(high_bit_padding[3:2]))
    else $error("high video bits not from padding");
  a_v54_pad: assert property (ce && dot.active && !eight_bit_colour_mode
    && video_bits_5_4_select |=> video_out[5:4] == $past(high_bit_padding[1:0]))
    else $error("bits 5-4 not from padding");
  a_plane_mask: assert property (ce && dot.active && gfx && !eight_bit_colour_mode
    && pde_eff && !video_bits_5_4_select && !blink_enable
    |=> video_out[5:0] == $past(palette_entries[dot.plane & plane_enable[3:0]]))
    else $error("plane enable not applied before palette");
  a_pack_rate: assert property (ce && dot.active && eight_bit_colour_mode && video_valid
    ##1 ce && dot.active |-> !video_valid)
    else $error("256-colour output faster than half dot rate");
  a_status_mux: assert property (ce && video_test_select == 2'b11
    |=> status_bits == $past(video_out[7:6]))
    else $error("status bits not routed from video 7 and 6");

  c_pack: cover property (ce && dot.active && eight_bit_colour_mode [*4]);
  c_index_data: cover property (index_wr ##[1:20] data_wr);
  c_ninth_copy: cover property (dot.ninth_dot && lgc && lgc_code && last_glyph);
endmodule : vac_attr_ctrl
`default_nettype wire

// *** vac_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module vac_host (
  input wire logic clk_sys,
  output var vac_pkg::vac_io_t io,
  input wire logic [7:0] io_rdata
);
  initial io = '0;
  // released lines show the inverse of the last value
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    io <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_sys);
    io <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : io_wr
  task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    io <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    io <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
    @(posedge clk_sys);
    d = io_rdata;
  endtask : io_rd
  // status read first so each pair starts at the index
  task automatic reg_wr(input logic [7:0] ix, input logic [7:0] v);
    logic [7:0] dummy;
    io_rd(vac_pkg::IO_STAT_COLR, dummy);
    io_wr(vac_pkg::IO_INDEX, ix);
    io_wr(vac_pkg::IO_INDEX, v);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] ix, output logic [7:0] v);
    logic [7:0] dummy;
    io_rd(vac_pkg::IO_STAT_MONO, dummy);
    io_wr(vac_pkg::IO_INDEX, ix);
    io_rd(vac_pkg::IO_DATA_RD, v);
  endtask : reg_rd
endmodule : vac_host
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  vac_pkg::vac_io_t io;
  logic [7:0] io_rdata;
  vac_pkg::vac_dot_t dot = '0;
  logic vrp = 1'b0;
  logic lcm = 1'b0;
  logic vsync = 1'b0;
  logic nine = 1'b0;
  logic wide = 1'b0;
  logic emap = 1'b0;
  logic [7:0] video_out;
  logic video_valid;
  logic [3:0] pan_shift;
  logic [1:0] status_bits;
  logic pde;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [7:0] rv;
  always #50 clk_sys = ~clk_sys;
  vac_host i_vac_host (.clk_sys(clk_sys), .io(io), .io_rdata(io_rdata));
  vac_attr_ctrl i_vac_attr_ctrl (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .io(io),
    .io_rdata(io_rdata), .dot(dot), .vertical_retrace_pulse(vrp),
    .line_compare_match(lcm), .vsync(vsync), .nine_dot_mode(nine),
    .pixel_path_width_bit(wide), .enhanced_mapping_bit(emap), .video_out(video_out),
    .video_valid(video_valid), .pan_shift(pan_shift), .status_bits(status_bits),
    .palette_display_enable(pde));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [5:0] pal(input logic [3:0] k);
    pal = 6'((k * 5) + 3);
  endfunction : pal
  function automatic vac_pkg::vac_dot_t gd(input logic [3:0] p);
    gd = '{active: 1'b1, glyph_dot: 1'b0, ninth_dot: 1'b0, cursor: 1'b0,
      char_code: 8'h00, attr: 8'h00, plane: p};
  endfunction : gd
  function automatic vac_pkg::vac_dot_t td(input logic [7:0] c, input logic [7:0] a,
      input logic g, input logic n);
    td = '{active: 1'b1, glyph_dot: g, ninth_dot: n, cursor: 1'b0,
      char_code: c, attr: a, plane: 4'h0};
  endfunction : td
  task automatic wr(input logic [7:0] ix, input logic [7:0] v);
    i_vac_host.reg_wr(ix, v);
  endtask : wr
  task automatic rdc(input logic [7:0] ix, input logic [7:0] exp);
    i_vac_host.reg_rd(ix, rv);
    chk(rv, exp);
  endtask : rdc
  task automatic iw(input logic [15:0] a, input logic [7:0] d);
    i_vac_host.io_wr(a, d);
  endtask : iw
  task automatic ir(input logic [15:0] a);
    i_vac_host.io_rd(a, rv);
  endtask : ir
  task automatic pix(input vac_pkg::vac_dot_t d, input logic [7:0] exp);
    @(posedge clk_sys);
    dot <= d;
    @(posedge clk_sys);
    #1;
    chk(video_out, exp);
  endtask : pix
  task automatic panc(input logic [3:0] exp);
    repeat (3) @(posedge clk_sys);
    #1;
    chk({4'h0, pan_shift}, {4'h0, exp});
  endtask : panc
  task automatic rtr(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      vrp <= 1'b1;
      @(posedge clk_sys);
      vrp <= 1'b0;
    end
  endtask : rtr
  task automatic t_regs;
    logic [7:0] msk [5];
    msk = '{8'hef, 8'hff, 8'h3f, 8'h0f, 8'h0f};
    chk({7'h00, pde}, 8'h00);
    rdc(8'h00, 8'h00);
    for (int i = 0; i < 5; i++) rdc(8'h30 + 8'(i), 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(8'h30 + 8'(i), 8'hff);
      rdc(8'h30 + 8'(i), msk[i]);
    end
    ir(vac_pkg::IO_INDEX);
    chk(rv, 8'h34);
    wr(8'h35, 8'h5a);
    rdc(8'h35, 8'h00);
    ir(16'h03c2);
    chk(rv, 8'h00);
  endtask : t_regs
  task automatic t_toggle;
    ir(vac_pkg::IO_STAT_COLR);
    iw(vac_pkg::IO_INDEX, 8'hf1);
    ir(vac_pkg::IO_INDEX);
    chk(rv, 8'h31);
    ir(vac_pkg::IO_DATA_RD);
    iw(vac_pkg::IO_INDEX, 8'h77);
    rdc(8'h31, 8'h77);
    iw(vac_pkg::IO_INDEX, 8'h32);
    ir(vac_pkg::IO_STAT_MONO);
    iw(vac_pkg::IO_INDEX, 8'h32);
    iw(vac_pkg::IO_INDEX, 8'h0a);
    rdc(8'h32, 8'h0a);
    rdc(8'h31, 8'h32);
  endtask : t_toggle
  task automatic t_palette;
    wr(8'h05, 8'h2a);
    chk({7'h00, pde}, 8'h00);
    rdc(8'h05, 8'h2a);
    wr(8'h25, 8'h15);
    chk({7'h00, pde}, 8'h01);
    rdc(8'h25, 8'h00);
    wide <= 1'b1;
    rdc(8'h25, 8'h2a);
    wide <= 1'b0;
    wr(8'h05, 8'hff);
    rdc(8'h05, 8'h3f);
    for (int k = 0; k < 16; k++) wr(8'(k), {2'b00, pal(4'(k))});
  endtask : t_palette
  task automatic t_gfx;
    logic [5:0] p;
    logic [7:0] v;
    logic [1:0] ex [4];
    wr(8'h30, 8'h01);
    wr(8'h32, 8'h0f);
    wr(8'h34, 8'h0c);
    for (int k = 0; k < 16; k++) pix(gd(4'(k)), {2'b11, pal(4'(k))});
    wr(8'h32, 8'h05);
    pix(gd(4'hf), {2'b11, pal(4'h5)});
    wr(8'h30, 8'h81);
    wr(8'h34, 8'h0e);
    p = pal(4'h4);
    pix(gd(4'h6), {4'he, p[3:0]});
    wr(8'h31, 8'ha5);
    pix('0, 8'ha5);
    p = pal(4'h9);
    v = {4'he, p[3:0]};
    ex = '{{v[2], v[0]}, {v[5], v[4]}, {v[3], v[1]}, {v[7], v[6]}};
    for (int s = 0; s < 4; s++) begin
      wr(8'h32, {2'b00, 2'(s), 4'hf});
      pix(gd(4'h9), v);
      @(posedge clk_sys);
      #1;
      chk({6'h00, status_bits}, {6'h00, ex[s]});
    end
  endtask : t_gfx
  task automatic t_256;
    logic [5:0] a;
    logic [5:0] b;
    a = pal(4'h3);
    b = pal(4'hc);
    wr(8'h30, 8'h41);
    @(posedge clk_sys);
    dot <= '0;
    @(posedge clk_sys);
    dot <= gd(4'h3);
    @(posedge clk_sys);
    dot <= gd(4'hc);
    #1;
    chk({7'h00, video_valid}, 8'h00);
    @(posedge clk_sys);
    #1;
    chk({7'h00, video_valid}, 8'h01);
    chk(video_out, {a[3:0], b[3:0]});
    @(posedge clk_sys);
    dot <= '0;
  endtask : t_256
  task automatic t_blink;
    wr(8'h34, 8'h00);
    wr(8'h30, 8'h09);
    pix(gd(4'h3), {2'b00, pal(4'h3)});
    rtr(16);
    pix(gd(4'h3), {2'b00, pal(4'hb)});
    rtr(15);
    pix(gd(4'h3), {2'b00, pal(4'hb)});
    rtr(1);
    pix(gd(4'h3), {2'b00, pal(4'h3)});
    rtr(16);
    wr(8'h30, 8'h01);
    pix(gd(4'h3), {2'b00, pal(4'h3)});
  endtask : t_blink
  task automatic t_text;
    logic [7:0] cc [4];
    logic [3:0] lg;
    cc = '{8'hbf, 8'hc0, 8'hdf, 8'he0};
    lg = 4'b0110;
    wr(8'h30, 8'h00);
    pix(td(8'h41, 8'h1e, 1'b1, 1'b0), {2'b00, pal(4'he)});
    pix(td(8'h41, 8'h1e, 1'b0, 1'b0), {2'b00, pal(4'h1)});
    pix(td(8'hc0, 8'h1e, 1'b1, 1'b0), {2'b00, pal(4'he)});
    pix(td(8'hc0, 8'h1e, 1'b0, 1'b1), {2'b00, pal(4'h1)});
    wr(8'h30, 8'h04);
    for (int i = 0; i < 4; i++) begin
      pix(td(cc[i], 8'h1e, 1'b1, 1'b0), {2'b00, pal(4'he)});
      pix(td(cc[i], 8'h1e, 1'b0, 1'b1), {2'b00, pal(lg[i] ? 4'he : 4'h1)});
    end
    wr(8'h30, 8'h02);
    pix(td(8'h41, 8'h07, 1'b1, 1'b0), {2'b00, pal(4'h7)});
    pix(td(8'h41, 8'h70, 1'b0, 1'b0), {2'b00, pal(4'h7)});
    pix(td(8'h41, 8'h70, 1'b1, 1'b0), {2'b00, pal(4'h0)});
  endtask : t_text
  task automatic t_pan;
    wr(8'h30, 8'h00);
    nine <= 1'b1;
    for (int c = 0; c < 9; c++) begin
      wr(8'h33, 8'(c));
      panc(c == 8 ? 4'h0 : 4'(c + 1));
    end
    nine <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      wr(8'h33, 8'(c));
      panc(4'(c));
    end
    wr(8'h30, 8'h41);
    for (int c = 0; c < 4; c++) begin
      wr(8'h33, 8'(2 * c));
      panc(4'(c));
    end
    wr(8'h30, 8'h21);
    wr(8'h33, 8'h03);
    lcm <= 1'b1;
    @(posedge clk_sys);
    lcm <= 1'b0;
    panc(4'h0);
    @(posedge clk_sys);
    vsync <= 1'b1;
    @(posedge clk_sys);
    vsync <= 1'b0;
    panc(4'h3);
    wr(8'h30, 8'h01);
    lcm <= 1'b1;
    @(posedge clk_sys);
    lcm <= 1'b0;
    panc(4'h3);
    @(posedge clk_sys);
    emap <= 1'b1;
    panc(4'h0);
    @(posedge clk_sys);
    emap <= 1'b0;
  endtask : t_pan
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs();
    t_toggle();
    t_palette();
    t_gfx();
    t_256();
    t_blink();
    t_text();
    t_pan();
    stop_test();
  end
  initial begin
    #(100 * 40000);
    n_mismatch++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
